// File: verilog/cantrx_ctrl.sv
`timescale 1ns/1ps
module cantrx_ctrl
	import cantrx_pkg::*;
#(
	parameter int EN_CYCLES = EN_CYC,
	parameter int TXTO_CYCLES = TXTO_CYC
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Serial control decode
	input  wire logic       mode_wr,
	input  wire logic [1:0] mode_wdata,
	input  wire logic [2:0] sys_mode,
	input  wire logic       fail_clr,
	// Host controller pins
	input  wire logic       tx_data_in,
	output logic            rx_data_out,
	// Bus side (analog front end)
	input  wire logic       bus_dominant,
	output logic            bus_line_pair_drive,
	output logic            bus_rx_enable,
	// Status
	output logic [1:0]      mode,
	output logic            en_done,
	output logic            can_fail,
	output logic            wake_event,
	output logic            woken
);

	cantrx_wake_if    wk ();
	logic [2:0]       tx_sync;
	logic [2:0]       bus_sync;
	logic             tx_s;
	logic             bus_s;
	logic [CNT_W-1:0] en_cnt;
	logic [CNT_W-1:0] to_cnt;
	logic             armed;
	logic             timed_out;
	logic             next_drive;
	logic             rx_bus_view;

	// Three-stage synchronisers; a change counts once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_sync  <= 3'h7;
			bus_sync <= 3'h0;
			tx_s     <= 1'b1;
			bus_s    <= 1'b0;
		end else begin
			tx_sync  <= {tx_sync[1:0], tx_data_in};
			bus_sync <= {bus_sync[1:0], bus_dominant};
			if (tx_sync[1] == tx_sync[2])
				tx_s <= tx_sync[2];
			if (bus_sync[1] == bus_sync[2])
				bus_s <= bus_sync[2];
		end
	end

	// Mode register with permission check and system fallback
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode <= MODE_RST;
		end else if (mode_wr) begin
			if (mode_wdata != MODE_NORMAL || sys_mode == SYS_NORMAL)
				mode <= mode_wdata;
		end else if (mode == MODE_NORMAL && sys_mode != SYS_NORMAL) begin
			mode <= MODE_WAKE;
		end
	end

	// Enabling delay counted from the write that selects normal mode
	always_ff @(posedge ref_clk) begin
		if (!rst_n || mode != MODE_NORMAL ||
			(mode_wr && mode_wdata == MODE_NORMAL)) begin
			en_cnt  <= '0;
			en_done <= 1'b0;
		end else if (en_cnt >= CNT_W'(EN_CYCLES - 1)) begin
			en_done <= 1'b1;
		end else begin
			en_cnt <= en_cnt + 1'b1;
		end
	end

	// Arming: a low input seen during enabling must go high before sending
	always_ff @(posedge ref_clk) begin
		if (!rst_n || mode != MODE_NORMAL)
			armed <= 1'b0;
		else if (!en_done)
			armed <= 1'b0;
		else if (tx_s)
			armed <= 1'b1;
	end

	// Dominant timeout; driver released until transmit input returns high
	always_ff @(posedge ref_clk) begin
		if (!rst_n || mode != MODE_NORMAL || tx_s) begin
			to_cnt    <= '0;
			timed_out <= 1'b0;
		end else if (to_cnt >= CNT_W'(TXTO_CYCLES - 1)) begin
			timed_out <= 1'b1;
		end else begin
			to_cnt <= to_cnt + 1'b1;
		end
	end

	// Failure flag; a new timeout wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			can_fail <= 1'b0;
		else if (!tx_s && mode == MODE_NORMAL &&
			to_cnt >= CNT_W'(TXTO_CYCLES - 1))
			can_fail <= 1'b1;
		else if (fail_clr)
			can_fail <= 1'b0;
	end

	// Driver only in normal mode, enabled, armed and not timed out;
	// en_done here also blocks a rewrite of normal from sending early
	always_comb begin
		next_drive = 1'b0;
		if (mode == MODE_NORMAL && en_done && armed && !timed_out)
			next_drive = !tx_s;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			bus_line_pair_drive <= 1'b0;
		else
			bus_line_pair_drive <= next_drive;
	end

	// Wake detector runs only in wake-capable mode and before a wake
	assign wk.arm     = (mode == MODE_WAKE) && !woken;
	assign wk.bus_dom = bus_s;

	cantrx_wake_det u_wake (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.wk      (wk)
	);

	// Woken latch held until a different mode is written
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			woken      <= 1'b0;
			wake_event <= 1'b0;
		end else begin
			wake_event <= wk.hit && mode == MODE_WAKE;
			if (wk.hit && mode == MODE_WAKE)
				woken <= 1'b1;
			else if (mode_wr && mode_wdata != MODE_WAKE)
				woken <= 1'b0;
			else if (mode != MODE_WAKE)
				woken <= 1'b0;
		end
	end

	// Receiver active in normal and receive-only modes
	assign bus_rx_enable = (mode == MODE_NORMAL) || (mode == MODE_RXONLY);
	assign rx_bus_view   = bus_rx_enable ? !bus_s : 1'b1;

	// Receive pin registered; forced low after a wake
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			rx_data_out <= 1'b1;
		else if (woken && mode == MODE_WAKE)
			rx_data_out <= 1'b0;
		else
			rx_data_out <= rx_bus_view;
	end

endmodule : cantrx_ctrl

// File: verilog/cantrx_pkg.sv
package cantrx_pkg;

	// Transceiver modes, coded as the serial control field
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_WAKE   = 2'h1;
	localparam logic [1:0] MODE_RXONLY = 2'h2;
	localparam logic [1:0] MODE_NORMAL = 2'h3;

	// System chip operating modes
	localparam logic [2:0] SYS_NORMAL   = 3'h0;
	localparam logic [2:0] SYS_STOP     = 3'h1;
	localparam logic [2:0] SYS_SLEEP    = 3'h2;
	localparam logic [2:0] SYS_RESTART  = 3'h3;
	localparam logic [2:0] SYS_FAILSAFE = 3'h4;

	// Clock rate
	localparam int CLK_HZ = 100_000_000;

	// Enabling time before the first dominant bit, in ns
	localparam int T_EN_NS = 200;
	localparam int EN_CYC  = (T_EN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Wake pattern phase limits, in ns (minimum rounds up, maximum down)
	localparam int T_WAKE1_NS = 500;
	localparam int T_WAKE2_NS = 1800;
	localparam int WAKE1_CYC  =
		(T_WAKE1_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int WAKE2_CYC  =
		(T_WAKE2_NS * (CLK_HZ / 1_000_000)) / 1000;

	// Transmit dominant timeout, in us
	localparam int T_TXTO_US = 2700;
	localparam int TXTO_CYC  = T_TXTO_US * (CLK_HZ / 1_000_000);

	// Counter widths
	localparam int CNT_W = 20;

	// Reset values
	localparam logic [1:0] MODE_RST = MODE_OFF;

endpackage : cantrx_pkg

// File: verilog/cantrx_wake_if.sv
`timescale 1ns/1ps
interface cantrx_wake_if;
	logic arm;
	logic bus_dom;
	logic hit;

	modport ctrl (output arm, output bus_dom, input hit);
	modport det (input arm, input bus_dom, output hit);
endinterface : cantrx_wake_if

// File: verilog/cantrx_wake_det.sv
`timescale 1ns/1ps
module cantrx_wake_det
	import cantrx_pkg::*;
(
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// Link to controller
	cantrx_wake_if.det        wk
);

	typedef enum logic [2:0] {
		WK_IDLE, WK_DOM1, WK_REC, WK_DOM2
	} cantrx_wk_e;

	cantrx_wk_e       state;
	logic [CNT_W-1:0] cnt;
	logic             hit;
	logic             in_win;

	// Phase length inside the pattern window
	assign in_win = (cnt >= CNT_W'(WAKE1_CYC)) && (cnt < CNT_W'(WAKE2_CYC));

	// Pattern walker; any out-of-window phase restarts the hunt
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !wk.arm) begin
			state <= WK_IDLE;
			cnt   <= '0;
			hit   <= 1'b0;
		end else begin
			hit <= 1'b0;
			if (cnt != {CNT_W{1'b1}})
				cnt <= cnt + 1'b1;
			case (state)
				WK_IDLE: begin
					cnt <= '0;
					if (wk.bus_dom)
						state <= WK_DOM1;
				end
				WK_DOM1: begin
					if (!wk.bus_dom) begin
						state <= in_win ? WK_REC : WK_IDLE;
						cnt   <= '0;
					end else if (cnt >= CNT_W'(WAKE2_CYC))
						state <= WK_IDLE;
				end
				WK_REC: begin
					if (wk.bus_dom) begin
						state <= in_win ? WK_DOM2 : WK_IDLE;
						cnt   <= '0;
					end else if (cnt >= CNT_W'(WAKE2_CYC))
						state <= WK_IDLE;
				end
				WK_DOM2: begin
					if (!wk.bus_dom || cnt >= CNT_W'(WAKE2_CYC)) begin
						hit   <= !wk.bus_dom && in_win;
						state <= WK_IDLE;
					end
				end
				default: state <= WK_IDLE;
			endcase
		end
	end

	assign wk.hit = hit;

endmodule : cantrx_wake_det

// File: testbench/cantrx_ctrl_monitor.sv
`timescale 1ns/1ps
module cantrx_ctrl_monitor
	import cantrx_pkg::*;
(
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rst_n,
	// Control
	input wire logic       mode_wr,
	input wire logic [1:0] mode_wdata,
	input wire logic [2:0] sys_mode,
	// Bus and pins
	input wire logic       bus_dominant,
	input wire logic       rx_data_out,
	input wire logic       bus_line_pair_drive,
	// Status
	input wire logic [1:0] mode,
	input wire logic       en_done,
	input wire logic       wake_event,
	input wire logic       woken
);
	// One clock domain, so clock and reset are given once
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Driver output lags the mode register by one edge
	property p_off;
		mode == MODE_OFF && $past(mode) == MODE_OFF |-> !bus_line_pair_drive;
	endproperty
	a_off: assert property (p_off) else $error("bus driven while off");
	property p_norm;
		mode_wr && mode_wdata == MODE_NORMAL && sys_mode != SYS_NORMAL &&
		mode != MODE_NORMAL |=> mode != MODE_NORMAL;
	endproperty
	a_norm: assert property (p_norm) else $error("normal taken");
	property p_drv;
		bus_line_pair_drive |-> $past(en_done) && $past(mode) == MODE_NORMAL;
	endproperty
	a_drv: assert property (p_drv) else $error("early drive");
	property p_rx;
		(mode == MODE_RXONLY && $stable(bus_dominant)) [*6] |->
		rx_data_out == !bus_dominant;
	endproperty
	a_rx: assert property (p_rx) else $error("rx level wrong");
	property p_rxo;
		mode == MODE_RXONLY && $past(mode) == MODE_RXONLY |->
		!bus_line_pair_drive;
	endproperty
	a_rxo: assert property (p_rxo) else $error("rx-only drives");
	property p_wk;
		$past(woken) && mode == MODE_WAKE && $past(mode) == MODE_WAKE |->
		!rx_data_out;
	endproperty
	a_wk: assert property (p_wk) else $error("rx high after wake");
	property p_wev;
		wake_event |-> mode == MODE_WAKE ##1 !wake_event;
	endproperty
	a_wev: assert property (p_wev) else $error("bad wake pulse");
	// Allow the fallback a few edges, since the write path is registered
	property p_fb;
		sys_mode != SYS_NORMAL && mode == MODE_NORMAL && !mode_wr |->
		##[1:3] mode == MODE_WAKE;
	endproperty
	a_fb: assert property (p_fb) else $error("no fallback");

	c_wake: cover property (wake_event);
	c_drive: cover property ($rose(bus_line_pair_drive));
	c_rxo: cover property (mode == MODE_RXONLY && !rx_data_out);
endmodule : cantrx_ctrl_monitor

bind cantrx_ctrl cantrx_ctrl_monitor u_cantrx_ctrl_monitor (
	.ref_clk(ref_clk), .rst_n(rst_n), .mode_wr(mode_wr),
	.mode_wdata(mode_wdata), .sys_mode(sys_mode),
	.bus_dominant(bus_dominant), .rx_data_out(rx_data_out),
	.bus_line_pair_drive(bus_line_pair_drive), .mode(mode),
	.en_done(en_done), .wake_event(wake_event), .woken(woken)
);

// File: testbench/cantrx_host_model.sv
`timescale 1ns/1ps
module cantrx_host_model (
	// Bench commands
	input  wire logic want_dom,
	input  wire logic obey,
	// Transceiver side
	input  wire logic en_done,
	input  wire logic bus_line_pair_drive,
	input  wire logic ext_dom,
	output logic      tx_data_in,
	output logic      bus_dominant
);
	// Holds recessive until enabled, unless told to misbehave
	assign tx_data_in = !(want_dom && (en_done || !obey));
	// Bus is dominant while any node drives it
	assign bus_dominant = bus_line_pair_drive || ext_dom;
endmodule : cantrx_host_model

// File: testbench/can_fd_transceiver_mode_control_bench.sv
`timescale 1ns/1ps
module can_fd_transceiver_mode_control_bench;
	import cantrx_pkg::*;
	logic       ref_clk = 0, rst_n = 0, mode_wr = 0, fail_clr = 0;
	logic       want_dom = 0, obey = 1, ext_dom = 0;
	logic [1:0] mode_wdata = 2'h0, mode;
	logic [2:0] sys_mode = 3'h0;
	logic       tx_data_in, rx_data_out, bus_dominant, bus_line_pair_drive;
	logic       en_done, can_fail, wake_event, woken, rx_en;
	int         fail_count = 0, cmp_count = 0, wake_cnt = 0;
	// Rows: system mode, written mode, expected mode
	logic [6:0] rows [9] = '{7'h0f, 7'h0a, 7'h00, 7'h1c, 7'h15, 7'h20,
		7'h35, 7'h2d, 7'h00};

	// Short timeout keeps the dominant-stuck case quick
	cantrx_ctrl #(.TXTO_CYCLES(50)) u_cantrx_ctrl (.ref_clk, .rst_n,
		.mode_wr, .mode_wdata, .sys_mode, .fail_clr, .tx_data_in,
		.rx_data_out, .bus_dominant, .bus_line_pair_drive,
		.bus_rx_enable(rx_en), .mode, .en_done, .can_fail, .wake_event,
		.woken);
	cantrx_host_model u_cantrx_host_model (.want_dom, .obey, .en_done,
		.bus_line_pair_drive, .ext_dom, .tx_data_in, .bus_dominant);

	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (wake_event === 1'b1) wake_cnt++;

	task cyc(input int n); repeat (n) @(posedge ref_clk); #1; endtask : cyc
	task chk(input logic [1:0] got, input logic [1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [2:0] s, input logic [1:0] m);
		sys_mode = s; mode_wdata = m; mode_wr = 1; cyc(1); mode_wr = 0; cyc(1);
	endtask : wr
	// Dominant, recessive, dominant, each d cycles, then idle
	task bus_wake_pattern(input int d);
		ext_dom = 1; cyc(d); ext_dom = 0; cyc(d); ext_dom = 1; cyc(d);
		ext_dom = 0; cyc(20);
	endtask : bus_wake_pattern
	task end_of_test;
		$display("mismatches %0d of %0d compares", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_of_test

	// The sequence needs about 1900 cycles
	initial begin
		#200000; fail_count++; end_of_test;
	end

	initial begin
		cyc(3); rst_n = 1;
		foreach (rows[i]) begin
			wr(rows[i][6:4], rows[i][3:2]); chk(mode, rows[i][1:0]);
		end
		// Host pulls tx low too early
		obey = 0; want_dom = 1; wr(SYS_NORMAL, MODE_NORMAL); cyc(30);
		chk(bus_line_pair_drive, 0);
		chk(en_done, 1);
		want_dom = 0; cyc(12); want_dom = 1; cyc(12);
		chk(bus_line_pair_drive, 1);
		chk(rx_data_out, 0);
		want_dom = 0; cyc(12); obey = 1;
		chk(bus_line_pair_drive, 0);
		chk(rx_data_out, 1);
		// Stuck dominant, release, resume, clear
		want_dom = 1; cyc(70);
		chk(bus_line_pair_drive, 0);
		chk(can_fail, 1);
		want_dom = 0; cyc(12); want_dom = 1; cyc(12);
		chk(bus_line_pair_drive, 1);
		want_dom = 0; fail_clr = 1; cyc(1); fail_clr = 0; cyc(1);
		chk(can_fail, 0);
		sys_mode = SYS_STOP; cyc(3); chk(mode, MODE_WAKE);
		bus_wake_pattern(100); chk(wake_cnt[1:0], 2'h1);
		chk(rx_data_out, 0);
		chk(woken, 1);
		wr(SYS_NORMAL, MODE_RXONLY); cyc(6); chk(rx_data_out, 1);
		chk(rx_en, 1);
		want_dom = 1; ext_dom = 1; cyc(8);
		chk(bus_line_pair_drive, 0);
		chk(rx_data_out, 0);
		want_dom = 0; ext_dom = 0; wr(SYS_NORMAL, MODE_WAKE);
		bus_wake_pattern(20); bus_wake_pattern(200); chk(wake_cnt[1:0], 2'h1);
		wr(SYS_NORMAL, MODE_OFF); chk(rx_en, 0);
		bus_wake_pattern(100); chk(wake_cnt[1:0], 2'h1);
		chk(woken, 0);
		wr(SYS_NORMAL, MODE_WAKE); bus_wake_pattern(100); chk(wake_cnt[1:0], 2'h2);
		// Second reset in mid-run
		rst_n = 0; cyc(3);
		chk(mode, MODE_OFF);
		chk(rx_data_out, 1);
		rst_n = 1; cyc(2);
		end_of_test;
	end
endmodule : can_fd_transceiver_mode_control_bench
